/* File: verilog/adc_seq_pkg.sv */
package adc_seq_pkg;
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         CONV_MAX_NS   = 7600;
  localparam int         CONV_MAX_CYC  = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam logic [9:0] CONV_LAST     = 10'(CONV_MAX_CYC - 1);
  localparam logic [1:0] EXT_LAG       = 2'h2;
  localparam logic [2:0] REPEAT_LAST   = 3'h7;
  localparam logic [5:0] HIGH_FILL     = 6'h3F;
  localparam int         RESULT_W      = 10;
  localparam int         MEM_WORDS     = 12;
  localparam logic [3:0] CH_MAX        = 4'hB;
  localparam logic [3:0] SHARED_CH_4   = 4'h3;
  localparam logic [3:0] SHARED_CH_12  = 4'hB;
  localparam logic [3:0] UPPER_LO_4    = 4'h2;
  localparam logic [3:0] UPPER_LO_8    = 4'h6;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam int         REG_BIT       = 7;
  localparam int         SCAN_HI_BIT   = 6;
  localparam int         SCAN_LO_BIT   = 5;
  localparam int         CS_HI_BIT     = 4;
  localparam int         CS_LO_BIT     = 1;
  localparam int         SGL_BIT       = 0;
  localparam int         SHARED_PIN_REF_ENABLE_BIT      = 5;
  localparam int         CLK_BIT       = 3;
  localparam logic [1:0] SCAN_UP       = 2'h0;
  localparam logic [1:0] SCAN_REPEAT   = 2'h1;
  localparam logic [1:0] SCAN_UPPER    = 2'h2;
  localparam logic [1:0] RST_SCAN      = 2'h0;
  localparam logic [3:0] RST_CS        = 4'h0;
  localparam logic       RST_SGL       = 1'b1;
  localparam logic       RST_CLK       = 1'b0;
  localparam logic       RST_REF       = 1'b0;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_CONV, ST_RD, ST_RD_ACK, ST_WAIT
  } link_state_t;
endpackage

/* File: verilog/adc_scan_sequencer_readout.sv */
`timescale 1ns/1ps
module adc_scan_sequencer_readout #(
  parameter int         NUM_INPUTS = 12,
  parameter logic [6:0] DEV_ADDR   = 7'h5A  // arbitrary value
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       conv_done_in,
  input  wire logic [9:0] conv_result_in,
  output logic            conv_start_out,
  output logic            conv_track_out,
  output logic [3:0]      conv_chan_out,
  output logic            conv_neg_out,
  output logic            conv_ref_gnd_out,
  output logic [3:0]      chan_pick_out,
  output logic [1:0]      sweep_mode_out,
  output logic            single_vs_pair_select_out,
  output logic            shared_pin_ref_enable_out,
  output logic            clk_mode_ext_out
);
  localparam logic [3:0] SHARED_CH  = (NUM_INPUTS == 4) ? adc_seq_pkg::SHARED_CH_4
                                                        : adc_seq_pkg::SHARED_CH_12;
  localparam logic       HAS_SHARED = (NUM_INPUTS != 8);
  localparam logic [3:0] UPPER_LO   = (NUM_INPUTS == 4) ? adc_seq_pkg::UPPER_LO_4
                                                        : adc_seq_pkg::UPPER_LO_8;
  localparam logic [3:0] MEM_LAST   = 4'(NUM_INPUTS - 1);
  localparam logic [3:0] MEM_FULL   = 4'(NUM_INPUTS);

  adc_seq_pkg::link_state_t st_r;
  logic [2:0] scl_sync_r, sda_sync_r;
  logic       scl_lvl_r, sda_lvl_r, scl_new, sda_new;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r, tx_r;
  logic       rw_r, ack_r, byte_sel_r, int_go_r, sda_oe_r, scl_oe_r;
  logic [3:0] cs_r;
  logic [1:0] scan_r;
  logic       sgl_r, clk_ext_r, ref_r, cfg_wr;
  logic       seq_on_r, busy_r, seq_fin_r, conv_start_r, conv_end, pair_r;
  logic [9:0] tmr_r;
  logic [3:0] ch_r, first_r, last_r, wp_r, cnt_r, rd_ptr_r, nxt_ptr, step;
  logic [2:0] reps_r;
  logic [9:0] mem_r [0:adc_seq_pkg::MEM_WORDS-1];
  logic [9:0] ext_res_r, rd_word, nxt_word;
  logic [3:0] conv_chan_r;
  logic       conv_neg_r, conv_ref_gnd_r, track_r;
  logic [1:0] ext_wait_r;
  logic       ext_go_r, ext_first_r, ext_sched, trk_set;

  function automatic logic [3:0] mask_cs(input logic [3:0] c);
    mask_cs = c;
    if (NUM_INPUTS == 4) mask_cs = {2'h0, c[1:0]};
    else if (NUM_INPUTS == 8) mask_cs = {1'h0, c[2:0]};
  endfunction

  function automatic logic [3:0] scan_first(input logic [3:0] c, input logic [1:0] md);
    case (md)
      adc_seq_pkg::SCAN_UP:    scan_first = 4'h0;
      adc_seq_pkg::SCAN_UPPER: scan_first = UPPER_LO;
      default:                 scan_first = c;
    endcase
  endfunction

  function automatic logic [3:0] scan_last(input logic [3:0] c, input logic [1:0] md,
                                           input logic sgl, input logic refm);
    logic [3:0] l;
    l = (c > adc_seq_pkg::CH_MAX) ? adc_seq_pkg::CH_MAX : c;
    if (md == adc_seq_pkg::SCAN_UPPER && l < UPPER_LO) l = UPPER_LO;
    if (md == adc_seq_pkg::SCAN_UP || md == adc_seq_pkg::SCAN_UPPER) begin
      if (sgl && refm && HAS_SHARED && l == SHARED_CH) l = SHARED_CH - 4'h1;
      if (!sgl) l = {l[3:1], 1'b0};
    end
    scan_last = l;
  endfunction

  function automatic logic [7:0] hi_byte(input logic [9:0] w);
    hi_byte = {adc_seq_pkg::HIGH_FILL, w[9:8]};
  endfunction

  // three-stage pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      scl_lvl_r  <= 1'b1;
      sda_lvl_r  <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
      scl_lvl_r  <= scl_new;
      sda_lvl_r  <= sda_new;
    end
  end

  always_comb begin
    scl_new   = (scl_sync_r[2] == scl_sync_r[1]) ? scl_sync_r[2] : scl_lvl_r;
    sda_new   = (sda_sync_r[2] == sda_sync_r[1]) ? sda_sync_r[2] : sda_lvl_r;
    scl_rise  = scl_new & ~scl_lvl_r;
    scl_fall  = ~scl_new & scl_lvl_r;
    start_det = scl_lvl_r & scl_new & sda_lvl_r & ~sda_new;
    stop_det  = scl_lvl_r & scl_new & ~sda_lvl_r & sda_new;
    cfg_wr    = (st_r == adc_seq_pkg::ST_WR) && scl_fall && bit_cnt_r == adc_seq_pkg::BYTE_BITS;
    nxt_ptr   = (rd_ptr_r + 4'h1 >= cnt_r) ? 4'h0 : rd_ptr_r + 4'h1;
    rd_word   = clk_ext_r ? ext_res_r : mem_r[rd_ptr_r];
    nxt_word  = clk_ext_r ? ext_res_r : mem_r[nxt_ptr];
    step      = pair_r ? 4'h2 : 4'h1;
    conv_end  = busy_r & (conv_done_in | (tmr_r == adc_seq_pkg::CONV_LAST));
    ext_sched = scl_rise & clk_ext_r & (((st_r == adc_seq_pkg::ST_ADDR_ACK) & rw_r)
              | ((st_r == adc_seq_pkg::ST_RD_ACK) & byte_sel_r & ~sda_new));
    trk_set   = (st_r == adc_seq_pkg::ST_ADDR) && scl_rise && bit_cnt_r == 4'h7
              && sh_r[6:0] == DEV_ADDR && sda_new && !clk_ext_r;
  end

  // serial slave: address, setup/config writes, result reads
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r       <= adc_seq_pkg::ST_IDLE;
      bit_cnt_r  <= 4'h0;
      sh_r       <= 8'h00;
      tx_r       <= 8'h00;
      rw_r       <= 1'b0;
      ack_r      <= 1'b0;
      byte_sel_r <= 1'b0;
      int_go_r   <= 1'b0;
      sda_oe_r   <= 1'b0;
      scl_oe_r   <= 1'b0;
      rd_ptr_r   <= 4'h0;
    end else begin
      int_go_r <= 1'b0;
      if ((st_r == adc_seq_pkg::ST_ADDR || st_r == adc_seq_pkg::ST_WR) && scl_rise) begin
        sh_r      <= {sh_r[6:0], sda_new};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      case (st_r)
        adc_seq_pkg::ST_ADDR: begin
          if (scl_fall && bit_cnt_r == adc_seq_pkg::BYTE_BITS) begin
            bit_cnt_r <= 4'h0;
            if (sh_r[7:1] == DEV_ADDR) begin
              sda_oe_r <= 1'b1;
              rw_r     <= sh_r[0];
              st_r     <= adc_seq_pkg::ST_ADDR_ACK;
            end else begin
              st_r <= adc_seq_pkg::ST_IDLE;
            end
          end
        end
        adc_seq_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            if (!rw_r) begin
              st_r <= adc_seq_pkg::ST_WR;
            end else if (clk_ext_r) begin
              tx_r       <= hi_byte(rd_word);
              byte_sel_r <= 1'b0;
              st_r       <= adc_seq_pkg::ST_RD;
            end else begin
              scl_oe_r <= 1'b1;
              int_go_r <= 1'b1;
              rd_ptr_r <= 4'h0;
              st_r     <= adc_seq_pkg::ST_CONV;
            end
          end
        end
        adc_seq_pkg::ST_WR: begin
          if (cfg_wr) begin
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b1;
            st_r      <= adc_seq_pkg::ST_WR_ACK;
          end
        end
        adc_seq_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            st_r     <= adc_seq_pkg::ST_WR;
          end
        end
        adc_seq_pkg::ST_CONV: begin
          if (seq_fin_r) begin
            scl_oe_r   <= 1'b0;
            tx_r       <= hi_byte(rd_word);
            byte_sel_r <= 1'b0;
            bit_cnt_r  <= 4'h0;
            st_r       <= adc_seq_pkg::ST_RD;
          end
        end
        adc_seq_pkg::ST_RD: begin
          if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            tx_r      <= {tx_r[6:0], 1'b0};
            sda_oe_r  <= (bit_cnt_r == 4'h7) ? 1'b0 : ~tx_r[6];
            if (bit_cnt_r == 4'h7) st_r <= adc_seq_pkg::ST_RD_ACK;
          end else if (bit_cnt_r == 4'h0) begin
            sda_oe_r <= ~tx_r[7];
          end
        end
        adc_seq_pkg::ST_RD_ACK: begin
          if (scl_rise) ack_r <= ~sda_new;
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (ack_r) begin
              byte_sel_r <= ~byte_sel_r;
              st_r       <= adc_seq_pkg::ST_RD;
              if (!byte_sel_r) begin
                tx_r <= rd_word[7:0];
              end else begin
                tx_r     <= hi_byte(nxt_word);
                rd_ptr_r <= nxt_ptr;
              end
            end else begin
              sda_oe_r <= 1'b0;
              st_r     <= adc_seq_pkg::ST_WAIT;
            end
          end
        end
        default: ;
      endcase
      if (stop_det && st_r != adc_seq_pkg::ST_CONV) begin
        st_r     <= adc_seq_pkg::ST_IDLE;
        sda_oe_r <= 1'b0;
      end
      if (start_det && st_r != adc_seq_pkg::ST_CONV) begin
        st_r      <= adc_seq_pkg::ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r  <= 1'b0;
      end
    end
  end

  // setup and configuration registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cs_r      <= adc_seq_pkg::RST_CS;
      scan_r    <= adc_seq_pkg::RST_SCAN;
      sgl_r     <= adc_seq_pkg::RST_SGL;
      clk_ext_r <= adc_seq_pkg::RST_CLK;
      ref_r     <= adc_seq_pkg::RST_REF;
    end else if (cfg_wr) begin
      if (sh_r[adc_seq_pkg::REG_BIT]) begin
        clk_ext_r <= sh_r[adc_seq_pkg::CLK_BIT];
        ref_r     <= sh_r[adc_seq_pkg::SHARED_PIN_REF_ENABLE_BIT];
      end else begin
        scan_r <= sh_r[adc_seq_pkg::SCAN_HI_BIT:adc_seq_pkg::SCAN_LO_BIT];
        sgl_r  <= sh_r[adc_seq_pkg::SGL_BIT];
        if (mask_cs(sh_r[adc_seq_pkg::CS_HI_BIT:adc_seq_pkg::CS_LO_BIT]) <= adc_seq_pkg::CH_MAX)
          cs_r <= mask_cs(sh_r[adc_seq_pkg::CS_HI_BIT:adc_seq_pkg::CS_LO_BIT]);
      end
    end
  end

  // external-clock conversions start two scl rising edges after the trigger
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_wait_r  <= 2'h0;
      ext_go_r    <= 1'b0;
      ext_first_r <= 1'b0;
    end else begin
      ext_go_r <= 1'b0;
      if (ext_sched) begin
        ext_wait_r  <= adc_seq_pkg::EXT_LAG;
        ext_first_r <= (st_r == adc_seq_pkg::ST_ADDR_ACK);
      end else if (ext_wait_r != 2'h0 && scl_rise) begin
        ext_wait_r <= ext_wait_r - 2'h1;
        ext_go_r   <= (ext_wait_r == 2'h1);
      end
    end
  end

  // conversion sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seq_on_r       <= 1'b0;
      busy_r         <= 1'b0;
      tmr_r          <= 10'h000;
      ch_r           <= 4'h0;
      first_r        <= 4'h0;
      last_r         <= 4'h0;
      reps_r         <= 3'h0;
      wp_r           <= 4'h0;
      cnt_r          <= 4'h0;
      seq_fin_r      <= 1'b0;
      conv_start_r   <= 1'b0;
      pair_r         <= 1'b0;
      ext_res_r      <= 10'h000;
      conv_chan_r    <= 4'h0;
      conv_neg_r     <= 1'b0;
      conv_ref_gnd_r <= 1'b0;
    end else begin
      seq_fin_r    <= 1'b0;
      conv_start_r <= 1'b0;
      if (int_go_r || (ext_go_r && ext_first_r)) begin
        ch_r     <= scan_first(cs_r, scan_r);
        first_r  <= scan_first(cs_r, scan_r);
        last_r   <= scan_last(cs_r, scan_r, sgl_r, ref_r);
        reps_r   <= (int_go_r && scan_r == adc_seq_pkg::SCAN_REPEAT) ? adc_seq_pkg::REPEAT_LAST
                                                                     : 3'h0;
        pair_r   <= ~sgl_r;
        wp_r     <= 4'h0;
        cnt_r    <= 4'h0;
        seq_on_r <= 1'b1;
      end else if (ext_go_r && !seq_on_r) begin
        ch_r     <= (ch_r == last_r) ? first_r : ch_r + step;
        seq_on_r <= 1'b1;
      end
      if (seq_on_r && !busy_r) begin
        conv_start_r   <= 1'b1;
        busy_r         <= 1'b1;
        tmr_r          <= 10'h000;
        conv_chan_r    <= ch_r;
        conv_neg_r     <= pair_r & ch_r[0];
        conv_ref_gnd_r <= pair_r & ref_r & HAS_SHARED & (ch_r[3:1] == SHARED_CH[3:1]);
      end
      if (busy_r) tmr_r <= tmr_r + 10'h001;
      if (conv_end) begin
        busy_r    <= 1'b0;
        ext_res_r <= conv_result_in;
        wp_r      <= (wp_r == MEM_LAST) ? 4'h0 : wp_r + 4'h1;
        if (cnt_r != MEM_FULL) cnt_r <= cnt_r + 4'h1;
        if (reps_r != 3'h0) begin
          reps_r <= reps_r - 3'h1;
        end else if (ch_r == last_r || clk_ext_r) begin
          seq_on_r  <= 1'b0;
          seq_fin_r <= ~clk_ext_r;
        end else begin
          ch_r <= ch_r + step;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (conv_end && !clk_ext_r) mem_r[wp_r] <= conv_result_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) track_r <= 1'b0;
    else if (trk_set || (ext_sched && st_r == adc_seq_pkg::ST_ADDR_ACK)) track_r <= 1'b1;
    else if (conv_start_r) track_r <= 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  assign scl_oe_out                = scl_oe_r;
  assign sda_oe_out                = sda_oe_r;
  assign conv_start_out            = conv_start_r;
  assign conv_track_out            = track_r;
  assign conv_chan_out             = conv_chan_r;
  assign conv_neg_out              = conv_neg_r;
  assign conv_ref_gnd_out          = conv_ref_gnd_r;
  assign chan_pick_out             = cs_r;
  assign sweep_mode_out            = scan_r;
  assign single_vs_pair_select_out = sgl_r;
  assign shared_pin_ref_enable_out = ref_r;
  assign clk_mode_ext_out          = clk_ext_r;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  rsv_chan_keep_a: assert property (cfg_wr && !sh_r[7] && mask_cs(sh_r[4:1]) > 4'hB
    |=> cs_r == $past(cs_r)) else $error("reserved channel code was accepted");
  variant_mask_a: assert property (NUM_INPUTS != 4 || chan_pick_out[3:2] == 2'h0)
    else $error("channel select not masked for variant");
  stretch_rel_a: assert property ($fell(scl_oe_out) |-> $past(seq_fin_r))
    else $error("clock released before scan stored");
  conv_bound_a: assert property (busy_r |-> tmr_r <= adc_seq_pkg::CONV_LAST)
    else $error("conversion exceeded its time");
  track_before_go_a: assert property (int_go_r |-> conv_track_out)
    else $error("tracking not started before conversion");
  first_byte_hi_a: assert property (st_r == adc_seq_pkg::ST_RD && !byte_sel_r
    && bit_cnt_r < 4'h6 |-> !sda_oe_out) else $error("fill bit driven low");
  nack_release_a: assert property (st_r == adc_seq_pkg::ST_RD_ACK && scl_fall && !ack_r
    && !start_det && !stop_det |=> !sda_oe_out && st_r == adc_seq_pkg::ST_WAIT)
    else $error("data line held after nack");
  ptr_wrap_a: assert property (cnt_r == 4'h0 || rd_ptr_r < cnt_r)
    else $error("read pointer beyond stored results");
  diff_step_a: assert property (conv_end && pair_r && reps_r == 3'h0 && ch_r != last_r
    && !clk_ext_r |=> ch_r == $past(ch_r) + 4'h2) else $error("pair scan step not two");
  addr_ack_a: assert property (st_r == adc_seq_pkg::ST_ADDR && scl_fall && bit_cnt_r == 4'h8
    && sh_r[7:1] == DEV_ADDR && !start_det && !stop_det |=> sda_oe_out)
    else $error("address not acknowledged");

  int_read_c: cover property (st_r == adc_seq_pkg::ST_CONV ##[1:1000] st_r == adc_seq_pkg::ST_RD);
  ext_read_c: cover property (ext_go_r && clk_ext_r);
  cfg_write_c: cover property (cfg_wr && !sh_r[7]);
  wrap_c: cover property (st_r == adc_seq_pkg::ST_RD_ACK && scl_fall && ack_r && byte_sel_r
    && nxt_ptr == 4'h0 && cnt_r > 4'h1);
endmodule

/* File: testbench/bus_master_model.sv */
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  int timeouts;
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
    timeouts = 0;
  end
  task automatic half();
    repeat (10) @(posedge clk_in);
  endtask
  // also a repeated start when entered with the clock low
  task automatic start_cond();
    sda_out <= 1'h1;
    half();
    scl_out <= 1'h1;
    half();
    sda_out <= 1'h0;
    half();
    scl_out <= 1'h0;
    half();
  endtask
  task automatic stop_cond();
    sda_out <= 1'h0;
    half();
    scl_out <= 1'h1;
    half();
    sda_out <= 1'h1;
    half();
  endtask
  // data only moves while the clock is low; waits out clock stretching
  task automatic clock_bit(input logic b, output logic seen);
    int n;
    sda_out <= b;
    half();
    scl_out <= 1'h1;
    n = 0;
    while (scl_in !== 1'h1 && n < 20000) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 20000) timeouts++;
    half();
    seen = sda_in;
    scl_out <= 1'h0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'h1, ack);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'h1, s);
      d[i] = s;
    end
    clock_bit(nack, s);
  endtask
endmodule

/* File: testbench/adc_scan_sequencer_readout_bench.sv */
`timescale 1ns/1ps
module adc_scan_sequencer_readout_bench;
  localparam logic [6:0] ADDR = 7'h2C;  // arbitrary value
  logic       clk_in, rst_in, m_scl, m_sda, scl_w, sda_w, scl_oe, sda_oe, scl_o, sda_o;
  logic       conv_done, conv_start, conv_track, conv_neg, conv_rg, sgl, refm, clkx, oe_d;
  logic [9:0] conv_result;
  logic [3:0] conv_chan, pick, cnt;
  logic [1:0] sweep;
  int         bad_count, checks, conv_lat, lat_cnt, stretch, stretch_max;
  logic [9:0] exp_q[$];
  assign scl_w = m_scl & (scl_oe ? scl_o : 1'h1);
  assign sda_w = m_sda & (sda_oe ? sda_o : 1'h1);
  adc_scan_sequencer_readout #(.NUM_INPUTS(12), .DEV_ADDR(ADDR)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .conv_done_in(conv_done), .conv_result_in(conv_result), .conv_start_out(conv_start),
    .conv_track_out(conv_track), .conv_chan_out(conv_chan), .conv_neg_out(conv_neg),
    .conv_ref_gnd_out(conv_rg), .chan_pick_out(pick), .sweep_mode_out(sweep),
    .single_vs_pair_select_out(sgl), .shared_pin_ref_enable_out(refm),
    .clk_mode_ext_out(clkx));
  bus_master_model m (.clk_in(clk_in), .scl_in(scl_w), .sda_in(sda_w), .scl_out(m_scl),
    .sda_out(m_sda));
  initial clk_in = 1'h0;
  always #4 clk_in = ~clk_in;
  // converter: result labels channel, polarity, ground flag and position in the scan
  always @(posedge clk_in) begin
    oe_d <= scl_oe;
    conv_done <= 1'h0;
    conv_result <= ~conv_result;
    if (scl_oe && !oe_d) cnt <= 4'h0;
    if (conv_start) lat_cnt <= conv_lat;
    else if (lat_cnt == 1) begin
      conv_done <= 1'h1;
      conv_result <= {conv_chan, conv_neg, conv_rg, cnt};
      cnt <= cnt + 4'h1;
      lat_cnt <= 0;
    end else if (lat_cnt > 1) lat_cnt <= lat_cnt - 1;
  end
  always @(posedge clk_in) begin
    if (scl_oe === 1'h1) begin
      stretch++;
      if (stretch > stretch_max) stretch_max = stretch;
    end else stretch = 0;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    bad_count += m.timeouts;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    logic a;
    m.start_cond();
    m.put_byte({ADDR, 1'h0}, a);
    check("address ack", 16'h0, {15'h0, a});
    m.put_byte(b, a);
    check("byte ack", 16'h0, {15'h0, a});
    m.stop_cond();
  endtask
  task automatic add(input logic [3:0] ch, input logic neg, input logic rg);
    exp_q.push_back({ch, neg, rg, 4'(exp_q.size())});
  endtask
  // can read more words than stored, to see the pointer wrap
  task automatic rd(input int words);
    logic       a;
    logic [7:0] hi, lo;
    stretch_max = 0;
    m.start_cond();
    m.put_byte({ADDR, 1'h1}, a);
    check("read ack", 16'h0, {15'h0, a});
    for (int i = 0; i < words; i++) begin
      m.get_byte(1'h0, hi);
      m.get_byte(i == words - 1, lo);
      check("result", {6'h3F, exp_q[i % exp_q.size()]}, {hi, lo});
    end
    check("stretch", 16'h1, 16'(stretch_max > 0 && stretch_max <= exp_q.size() * 950));
    repeat (12) @(posedge clk_in);
    check("data release", 16'h0, {15'h0, sda_oe});
    m.stop_cond();
    exp_q.delete();
  endtask
  initial begin
    logic       a;
    logic [7:0] hi, lo;
    rst_in = 1'h1;
    {conv_done, conv_result, cnt, oe_d} = '0;
    {lat_cnt, bad_count, checks, stretch, stretch_max} = '0;
    conv_lat = 900;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (6) @(posedge clk_in);
    check("power-up", 16'h004, {pick, sweep, sgl, refm, clkx});
    m.start_cond();
    m.put_byte({ADDR ^ 7'h01, 1'h1}, a);
    check("foreign ack", 16'h1, {15'h0, a});
    m.stop_cond();
    wr({1'h0, 2'h3, 4'h5, 1'h1});
    check("config", 16'h6B, {sweep, pick, sgl});
    add(4'h5, 1'h0, 1'h0);
    rd(3);
    conv_lat = 20;
    wr({1'h0, 2'h0, 4'hC, 1'h1});
    check("reserved code", 16'h05, {sweep, pick});
    for (int i = 0; i < 6; i++) add(4'(i), 1'h0, 1'h0);
    rd(7);
    wr({1'h0, 2'h1, 4'h9, 1'h1});
    repeat (8) add(4'h9, 1'h0, 1'h0);
    rd(8);
    wr({1'h0, 2'h2, 4'h8, 1'h1});
    for (int i = 6; i < 9; i++) add(4'(i), 1'h0, 1'h0);
    rd(3);
    wr({1'h0, 2'h2, 4'h3, 1'h1});
    add(4'h6, 1'h0, 1'h0);
    rd(2);
    wr(8'hA0);
    check("setup", 16'h2, {refm, clkx});
    wr({1'h0, 2'h0, 4'hB, 1'h1});
    for (int i = 0; i < 11; i++) add(4'(i), 1'h0, 1'h0);
    rd(11);
    wr({1'h0, 2'h0, 4'h4, 1'h0});
    for (int i = 0; i < 6; i += 2) add(4'(i), 1'h0, 1'h0);
    rd(3);
    wr({1'h0, 2'h3, 4'hB, 1'h0});
    add(4'hB, 1'h1, 1'h1);
    rd(1);
    wr({1'h0, 2'h3, 4'h3, 1'h0});
    add(4'h3, 1'h1, 1'h0);
    rd(1);
    wr(8'h88);
    check("clock mode", 16'h1, {refm, clkx});
    // external clock: high byte from the previous result, low byte from the fresh conversion
    m.start_cond();
    m.put_byte({ADDR, 1'h1}, a);
    check("ext read ack", 16'h0, {15'h0, a});
    m.get_byte(1'h0, hi);
    m.get_byte(1'h1, lo);
    check("ext result", 16'hFCE1, {hi, lo});
    m.stop_cond();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    $display("watchdog expired");
    bad_count++;
    stop_test();
  end
endmodule
